// file: shared/dimac_regs.svh
// Register map, field positions, reset values and timing counts of the input macro block
`ifndef DIMAC_REGS_SVH
`define DIMAC_REGS_SVH
// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define DIMAC_A_CTRL 4'h0
`define DIMAC_A_PRE0 4'h1
`define DIMAC_A_PRE1 4'h2
`define DIMAC_A_PRE2 4'h3
`define DIMAC_A_PRE3 4'h4
`define DIMAC_A_KEY 4'h5
`define DIMAC_A_STAT 4'h6
`define DIMAC_A_SPD 4'h7
// ----------------------------------------
// Control fields
// ----------------------------------------
`define DIMAC_C_MAC 2:0
`define DIMAC_C_SRC 4:3
`define DIMAC_C_KEN 5
`define DIMAC_C_KPRE 6
`define DIMAC_C_AUTO 7
`define DIMAC_C_AI2F 8
`define DIMAC_C_PI 9
`define DIMAC_CTRL_W 10
`define DIMAC_CTRL_RST 10'h000
// ----------------------------------------
// Keypad command bits
// ----------------------------------------
`define DIMAC_K_START 0
`define DIMAC_K_STOP 1
`define DIMAC_K_TCLR 2
// ----------------------------------------
// Trip codes and power-up settle time
// ----------------------------------------
`define DIMAC_TRIP_EXT 4'h1
`define DIMAC_TRIP_THERM 4'h2
`define DIMAC_BOOT_CYC 2'h3
`endif

// file: shared/dimac_pkg.sv
// Types shared by the input macro block
`default_nettype none
package dimac_pkg;
  typedef enum logic [2:0] {
    MAC_LATCH_DIR,
    MAC_RUN_DIR,
    MAC_EDGE,
    MAC_PAIR,
    MAC_PRESET
  } dimac_macro_type;

  typedef enum logic [1:0] {
    SRC_TERMINAL,
    SRC_KEYPAD,
    SRC_FIELDBUS,
    SRC_MASTER
  } dimac_src_type;
endpackage : dimac_pkg
`default_nettype wire

// file: hdl/dimac_sync_edge.sv
// Two-stage synchroniser with edge detection for terminal inputs
`timescale 1ns/1ns
`default_nettype none
module dimac_sync_edge #(
  parameter int N = 4
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Synchronous reset, low
  input wire logic [N-1:0] pin, // Raw terminal levels
  output logic [N-1:0] lvl, // Synchronised level
  output logic [N-1:0] rise, // One-cycle closing pulse
  output logic [N-1:0] fall // One-cycle opening pulse
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  // First stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lvl = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule : dimac_sync_edge
`default_nettype wire

// file: hdl/dimac_core.sv
// Digital input macro interpreter: terminals to run, direction, stop, trip and speed reference
//
// Notes on behaviour
// - Open latched stop contact keeps drive stopped
// - Latched run runs only while held closed
// - Latched direction inputs select forward or reverse
// - Run-direction inputs latched, opening commands stop
// - Keypad mode: enable starts or arms start
// - Fieldbus start ignored without hardware enable
// - Normally-open start acts on rising edge
// - Simultaneous paired closure starts, stop held
// - Normally-closed stop acts on falling edge
// - Directional edge starts need stop held closed
// - Paired simultaneous closure gives fast stop
// - Normally-closed fast stop on falling edge
// - External trip latches; code picks format
// - Step-up adds first preset per closure
// - Step-down subtracts first preset per closure
// - Generic NO closes, NC opens to act
// - Two inputs pick one of four presets
// - Reference routed from the selected source
// - Fieldbus reference follows chosen link
// - Auto-start setting gates start after power-up
// - Keypad start-mode fixes starting speed
// - Macro and source settings assign functions
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "dimac_regs.svh"
module dimac_core #(
  parameter int W = 16
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic nrst, // Synchronous reset, low
  input wire logic [3:0] term_in, // Digital terminals, asynchronous
  input wire logic [W-1:0] first_analog_reference, // First analog reference
  input wire logic [W-1:0] second_analog_reference, // Second analog reference
  input wire logic [W-1:0] pi_controller_reference, // PI controller output
  input wire logic [W-1:0] fieldbus_reference_select, // Serial fieldbus reference
  input wire logic [W-1:0] ml_ref, // Master link reference
  input wire logic fb_start, // Fieldbus start pulse
  input wire logic fb_stop, // Fieldbus stop pulse
  input wire logic [3:0] addr, // Register index
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  output logic run_cmd, // Run command
  output logic dir_rev, // Reverse rotation
  output logic fast_stop, // Use fast-stop ramp
  output logic trip, // External trip active
  output logic [3:0] trip_code, // Trip code shown
  output logic [W-1:0] speed_ref // Speed reference
);
  // ----------------------------------------
  // Terminal synchronisation
  // ----------------------------------------
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;

  dimac_sync_edge #(.N(4)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(term_in),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [`DIMAC_CTRL_W-1:0] ctrl_r;
  logic [W-1:0] pre_r [0:3];
  logic [31:0] rdata_r;
  logic run_r, run_nxt;
  logic rev_r, rev_nxt;
  logic fs_r, fs_nxt;
  logic trip_r;
  logic [3:0] tcode_r;
  logic [W-1:0] spd_r, spd_nxt;
  logic [W-1:0] kspd_r;
  logic lock_r;
  logic [1:0] boot_r;
  logic trip_set;
  logic key_start, key_stop, trip_clr;
  logic start_ev;
  dimac_pkg::dimac_macro_type mac;
  dimac_pkg::dimac_src_type src;

  assign mac = dimac_pkg::dimac_macro_type'(ctrl_r[`DIMAC_C_MAC]);
  assign src = dimac_pkg::dimac_src_type'(ctrl_r[`DIMAC_C_SRC]);
  assign key_start = wr && addr == `DIMAC_A_KEY && wdata[`DIMAC_K_START];
  assign key_stop = wr && addr == `DIMAC_A_KEY && wdata[`DIMAC_K_STOP];
  assign trip_clr = wr && addr == `DIMAC_A_KEY && wdata[`DIMAC_K_TCLR];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_r <= `DIMAC_CTRL_RST;
    end else if (wr && addr == `DIMAC_A_CTRL) begin
      ctrl_r <= wdata[`DIMAC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        pre_r[i] <= '0;
      end
    end else if (wr && addr >= `DIMAC_A_PRE0 && addr <= `DIMAC_A_PRE3) begin
      pre_r[2'(addr - `DIMAC_A_PRE0)] <= wdata[W-1:0];
    end
  end

  // Unmapped and write-only indices read as zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (rd) begin
      case (addr)
        `DIMAC_A_CTRL: rdata_r <= 32'(ctrl_r);
        `DIMAC_A_PRE0, `DIMAC_A_PRE1, `DIMAC_A_PRE2, `DIMAC_A_PRE3:
          rdata_r <= 32'(pre_r[2'(addr - `DIMAC_A_PRE0)]);
        `DIMAC_A_STAT: rdata_r <= 32'({lvl, tcode_r, lock_r, trip_r, fs_r, rev_r, run_r});
        `DIMAC_A_SPD: rdata_r <= 32'(spd_r);
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ----------------------------------------
  // Power-up start lock
  // ----------------------------------------
  // Synchroniser resets low, so the start level is judged only once it settles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      boot_r <= '0;
      lock_r <= 1'b1;
    end else begin
      if (boot_r != `DIMAC_BOOT_CYC) begin
        boot_r <= boot_r + 2'h1;
      end else if (ctrl_r[`DIMAC_C_AUTO] || !lvl[0]) begin
        lock_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Command decoding
  // ----------------------------------------
  always_comb begin
    run_nxt = run_r;
    rev_nxt = rev_r;
    fs_nxt = fs_r;
    trip_set = 1'b0;
    if (src == dimac_pkg::SRC_TERMINAL) begin
      case (mac)
        dimac_pkg::MAC_LATCH_DIR: begin
          run_nxt = lvl[0];
          if (lvl[2]) begin
            rev_nxt = 1'b1;
          end else if (lvl[1]) begin
            rev_nxt = 1'b0;
          end
        end
        dimac_pkg::MAC_RUN_DIR: begin
          run_nxt = lvl[0] ^ lvl[1];
          if (lvl[1] && !lvl[0]) begin
            rev_nxt = 1'b1;
          end else if (lvl[0] && !lvl[1]) begin
            rev_nxt = 1'b0;
          end
          if ((rise[0] && lvl[1]) || (rise[1] && lvl[0])) begin
            fs_nxt = 1'b1;
          end
          trip_set = fall[2];
        end
        dimac_pkg::MAC_EDGE: begin
          if (fall[1]) begin
            run_nxt = 1'b0;
          end else if (rise[0] && lvl[1]) begin
            run_nxt = 1'b1;
            rev_nxt = 1'b0;
          end else if (rise[3] && lvl[1]) begin
            run_nxt = 1'b1;
            rev_nxt = 1'b1;
          end
          if (fall[2]) begin
            run_nxt = 1'b0;
            fs_nxt = 1'b1;
          end
        end
        dimac_pkg::MAC_PAIR: begin
          if (fall[1]) begin
            run_nxt = 1'b0;
          end else if (((rise[0] && lvl[2]) || (rise[2] && lvl[0])) && lvl[1]) begin
            run_nxt = 1'b1;
          end
          trip_set = fall[3];
        end
        dimac_pkg::MAC_PRESET: begin
          run_nxt = lvl[0];
          trip_set = fall[3];
        end
        default: begin
          run_nxt = 1'b0;
        end
      endcase
    end else if (src == dimac_pkg::SRC_KEYPAD) begin
      rev_nxt = lvl[3];
      if (!lvl[0] || key_stop) begin
        run_nxt = 1'b0;
      end else if (ctrl_r[`DIMAC_C_KEN] || key_start) begin
        run_nxt = 1'b1;
      end
    end else begin
      rev_nxt = lvl[3];
      if (!lvl[0] || fb_stop) begin
        run_nxt = 1'b0;
      end else if (fb_start) begin
        run_nxt = 1'b1;
      end
    end
    if (trip_r || trip_set || lock_r) begin
      run_nxt = 1'b0;
    end
    // Only a start that really happens leaves the fast-stop ramp behind
    if (run_nxt && !run_r) begin
      fs_nxt = 1'b0;
    end
  end

  assign start_ev = run_nxt && !run_r;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      run_r <= 1'b0;
      rev_r <= 1'b0;
      fs_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      rev_r <= rev_nxt;
      fs_r <= fs_nxt;
    end
  end

  // Set beats clear so a trip in the clearing cycle is kept
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      trip_r <= 1'b0;
      tcode_r <= '0;
    end else if (trip_set) begin
      trip_r <= 1'b1;
      tcode_r <= ctrl_r[`DIMAC_C_AI2F] ? `DIMAC_TRIP_THERM : `DIMAC_TRIP_EXT;
    end else if (trip_clr) begin
      trip_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Speed reference
  // ----------------------------------------
  // Step-down floors at zero, step-up saturates at full scale
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      kspd_r <= '0;
    end else if (src != dimac_pkg::SRC_TERMINAL) begin
      if (src == dimac_pkg::SRC_KEYPAD && start_ev && ctrl_r[`DIMAC_C_KPRE]) begin
        kspd_r <= pre_r[0];
      end else if (rise[1] && !rise[2]) begin
        kspd_r <= (kspd_r > ~pre_r[0]) ? '1 : kspd_r + pre_r[0];
      end else if (rise[2] && !rise[1]) begin
        kspd_r <= (kspd_r < pre_r[0]) ? '0 : kspd_r - pre_r[0];
      end
    end
  end

  always_comb begin
    spd_nxt = first_analog_reference;
    case (src)
      dimac_pkg::SRC_TERMINAL: begin
        case (mac)
          dimac_pkg::MAC_LATCH_DIR: spd_nxt = lvl[3] ? pre_r[0] : first_analog_reference;
          dimac_pkg::MAC_RUN_DIR: spd_nxt = lvl[3] ? second_analog_reference : first_analog_reference;
          dimac_pkg::MAC_PRESET: spd_nxt = pre_r[{lvl[2], lvl[1]}];
          default: spd_nxt = first_analog_reference;
        endcase
      end
      dimac_pkg::SRC_KEYPAD: spd_nxt = kspd_r;
      dimac_pkg::SRC_FIELDBUS: spd_nxt = fieldbus_reference_select;
      dimac_pkg::SRC_MASTER: spd_nxt = ml_ref;
      default: spd_nxt = first_analog_reference;
    endcase
    if (ctrl_r[`DIMAC_C_PI]) begin
      spd_nxt = pi_controller_reference;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      spd_r <= '0;
    end else begin
      spd_r <= spd_nxt;
    end
  end

  assign rdata = rdata_r;
  assign run_cmd = run_r;
  assign dir_rev = rev_r;
  assign fast_stop = fs_r;
  assign trip = trip_r;
  assign trip_code = tcode_r;
  assign speed_ref = spd_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic term_c;
  assign term_c = src == dimac_pkg::SRC_TERMINAL;

  sequence s_latch_open;
    term_c && (mac == dimac_pkg::MAC_LATCH_DIR || mac == dimac_pkg::MAC_PRESET) && !lvl[0];
  endsequence
  sequence s_edge_fwd;
    term_c && mac == dimac_pkg::MAC_EDGE && rise[0] && lvl[1] && !fall[2] && !lock_r && !trip_r;
  endsequence
  sequence s_trip_open;
    term_c && mac == dimac_pkg::MAC_PRESET && fall[3];
  endsequence

  a_stop_level: assert property (s_latch_open |=> !run_cmd)
    else $error("run while latched stop open");
  a_run_hold: assert property (term_c && mac == dimac_pkg::MAC_LATCH_DIR && lvl[0] && !lock_r
    && !trip_r |=> run_cmd)
    else $error("latched run not followed");
  a_dir_sel: assert property (term_c && mac == dimac_pkg::MAC_LATCH_DIR && lvl[2] |=> dir_rev)
    else $error("reverse select ignored");
  a_run_rev: assert property (term_c && mac == dimac_pkg::MAC_RUN_DIR && lvl[1] && !lvl[0]
    && !lock_r && !trip_r && !fall[2] |=> run_cmd && dir_rev)
    else $error("run reverse not commanded");
  a_fb_enable: assert property (src == dimac_pkg::SRC_FIELDBUS && !lvl[0] |=> !run_cmd)
    else $error("fieldbus run without enable");
  a_edge_start: assert property (s_edge_fwd |=> run_cmd && !dir_rev ##1 (run_cmd || !$past(term_c)
    || $past(mac) != dimac_pkg::MAC_EDGE || $past(fall[1]) || $past(fall[2])))
    else $error("edge start missed");
  a_nc_stop: assert property (term_c && mac == dimac_pkg::MAC_EDGE && fall[1] |=> !run_cmd)
    else $error("nc stop missed");
  a_fast_stop: assert property (term_c && mac == dimac_pkg::MAC_EDGE && fall[2]
    |=> fast_stop && !run_cmd)
    else $error("fast stop missed");
  a_trip_latch: assert property (s_trip_open ##1 !trip_clr |=> trip && !run_cmd)
    else $error("external trip not latched");
  a_step_up: assert property (src == dimac_pkg::SRC_KEYPAD && rise[1] && !rise[2] && !start_ev
    && kspd_r <= ~pre_r[0] |=> kspd_r == $past(kspd_r) + $past(pre_r[0]))
    else $error("step up wrong");
endmodule : dimac_core
`default_nettype wire

// file: bench/dimac_contacts.sv
// Contact model standing on the terminal side of the input macro core
`timescale 1ns/1ns
`default_nettype none
module dimac_contacts (
  input wire logic sys_clk, // Clock
  input wire logic slow, // Contacts land two cycles late
  input wire logic [3:0] want, // Contact state asked for
  output logic [3:0] term_in // Contact levels, high = closed
);
  logic [3:0] mid1;
  logic [3:0] mid2;
  initial begin
    term_in = 4'h0;
    mid1 = 4'h0;
    mid2 = 4'h0;
  end
  // Clean contacts; NO closes, NC opens to act, held long enough for one event
  always @(posedge sys_clk) begin
    mid1 <= want;
    mid2 <= mid1;
    term_in <= slow ? mid2 : want;
  end
endmodule : dimac_contacts
`default_nettype wire

// file: bench/testbench.sv
// Testbench for the input macro core: registers, macros, sources and power-up lock
`timescale 1ns/1ns
`default_nettype none
`include "dimac_regs.svh"
module testbench;
  logic sys_clk;
  logic nrst;
  logic wr;
  logic rd;
  logic rd_q;
  logic slow;
  logic fb_start;
  logic fb_stop;
  logic [3:0] want;
  logic [3:0] term_in;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] pre[4];
  logic [15:0] ai1;
  logic [15:0] ai2;
  logic [15:0] pi;
  logic [15:0] fb;
  logic [15:0] ml;
  logic [67:0] n;
  logic [67:0] notes[$];
  logic run_cmd;
  logic dir_rev;
  logic fast_stop;
  logic trip;
  logic [3:0] trip_code;
  logic [15:0] speed_ref;
  logic [31:0] outs;
  int miscompares;
  int comparisons;
  localparam logic [31:0] RUN = 32'h3;
  localparam logic [31:0] FST = 32'h4;
  localparam logic [31:0] TRP = 32'h1e8;
  localparam logic [31:0] LCK = 32'h10;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  dimac_contacts contacts (.sys_clk(sys_clk), .slow(slow), .want(want), .term_in(term_in));
  dimac_core #(.W(16)) uut (.sys_clk(sys_clk), .nrst(nrst), .term_in(term_in), .first_analog_reference(ai1),
    .second_analog_reference(ai2), .pi_controller_reference(pi), .fieldbus_reference_select(fb), .ml_ref(ml), .fb_start(fb_start), .fb_stop(fb_stop),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_cmd(run_cmd), .dir_rev(dir_rev),
    .fast_stop(fast_stop), .trip(trip), .trip_code(trip_code), .speed_ref(speed_ref));

  // Output pins laid out as the status word, lock and levels left out
  assign outs = {23'h0, trip_code, 1'b0, trip, fast_stop, dir_rev, run_cmd};

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Read data only stand in the cycle after the strobe
  always @(posedge sys_clk) rd_q <= rd;
  always @(negedge sys_clk) begin
    if (rd_q) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("[FAIL] %0t read data with no expectation", $time);
      end else begin
        n = notes.pop_front();
        chk(rdata & n[31:0], n[63:32]);
        if (n[67:64] == `DIMAC_A_STAT) begin
          chk(outs & n[31:0] & 32'h1ef, n[63:32] & 32'h1ef);
        end else if (n[67:64] == `DIMAC_A_SPD) begin
          chk(32'(speed_ref), n[63:32]);
        end
      end
    end
  end

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    #300000;
    miscompares++;
    conclude();
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    notes.push_back({a, e & m, m});
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask : rreg

  task automatic sts(input logic [31:0] e, input logic [31:0] m);
    rreg(`DIMAC_A_STAT, e, m);
  endtask : sts

  task automatic spd(input logic [31:0] e);
    rreg(`DIMAC_A_SPD, e, 32'hffffffff);
  endtask : spd

  task automatic term(input logic [3:0] v);
    @(posedge sys_clk);
    want <= v;
    repeat (10) @(posedge sys_clk);
  endtask : term

  task automatic pulse(input logic [3:0] on, input logic [3:0] off);
    term(on);
    term(off);
  endtask : pulse

  task automatic fbp(input logic s);
    @(posedge sys_clk);
    fb_start <= s;
    fb_stop <= ~s;
    @(posedge sys_clk);
    fb_start <= 1'b0;
    fb_stop <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : fbp

  function automatic logic [31:0] ctl(input logic [4:0] hi, input logic [1:0] s, input logic [2:0] m);
    return {22'h0, hi, s, m};
  endfunction : ctl

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {nrst, wr, rd, slow, fb_start, fb_stop} = 6'h0;
    want = 4'h0;
    addr = 4'h0;
    wdata = 32'h0;
    void'($urandom(78));
    {ai1, ai2, pi, fb, ml} = {$urandom(), $urandom(), 16'($urandom())};
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rreg(`DIMAC_A_CTRL, 32'h0, 32'hffffffff);
    sts(32'h0, 32'h1fff);
    rreg(`DIMAC_A_KEY, 32'h0, 32'hffffffff);
    rreg(4'h9, 32'h0, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      pre[i] = $urandom() & ((i == 0) ? 32'hfff : 32'hffffffff) | 32'h1;
      rreg(4'(i + 1), 32'h0, 32'hffffffff);
      wreg(4'(i + 1), pre[i]);
      pre[i] = pre[i] & 32'hffff;
      rreg(4'(i + 1), pre[i], 32'hffffffff);
    end
    wreg(`DIMAC_A_CTRL, 32'hfffffd44);
    wreg(4'h9, 32'h3ff);
    rreg(`DIMAC_A_CTRL, 32'h144, 32'hffffffff);
    wreg(`DIMAC_A_CTRL, 32'h0);
    wreg(`DIMAC_A_KEY, 32'h4);
    done("registers");
    term(4'h3);
    sts(32'h1, RUN);
    sts(32'h600, 32'h1e00);
    term(4'h7);
    sts(32'h3, RUN);
    term(4'h5);
    sts(32'h3, RUN);
    spd(ai1);
    term(4'hd);
    spd(pre[0]);
    wreg(`DIMAC_A_CTRL, ctl(5'h10, 2'h0, 3'h0));
    spd(pi);
    wreg(`DIMAC_A_CTRL, 32'h0);
    term(4'h4);
    sts(32'h2, RUN);
    done("latched");
    wreg(`DIMAC_A_CTRL, ctl(5'h0, 2'h0, 3'h1));
    wreg(`DIMAC_A_KEY, 32'h4);
    term(4'h5);
    sts(32'h1, RUN);
    term(4'h4);
    sts(32'h0, RUN);
    term(4'h6);
    sts(32'h3, RUN);
    pulse(4'h7, 4'h4);
    sts(32'h4, FST | 32'h1);
    pulse(4'hc, 4'hc);
    spd(ai2);
    term(4'h4);
    spd(ai1);
    for (int f = 0; f < 2; f++) begin
      wreg(`DIMAC_A_CTRL, ctl({1'b0, f[0], 3'h0}, 2'h0, 3'h1));
      pulse(4'h0, 4'h4);
      sts(((f == 0) ? 32'h20 : 32'h40) | 32'h8, TRP);
      term(4'h5);
      sts(32'h0, RUN);
      term(4'h4);
      wreg(`DIMAC_A_KEY, 32'h4);
      sts((f == 0) ? 32'h20 : 32'h40, TRP);
    end
    done("run direction");
    slow <= 1'b1;
    wreg(`DIMAC_A_CTRL, ctl(5'h0, 2'h0, 3'h2));
    term(4'h6);
    pulse(4'h7, 4'h6);
    sts(32'h1, RUN);
    pulse(4'h4, 4'h6);
    sts(32'h0, RUN);
    pulse(4'he, 4'h6);
    sts(32'h3, RUN);
    pulse(4'h2, 4'h6);
    sts(32'h4, FST | 32'h1);
    term(4'h4);
    pulse(4'h5, 4'h4);
    sts(32'h2, RUN);
    term(4'ha);
    slow <= 1'b0;
    done("edge");
    wreg(`DIMAC_A_CTRL, ctl(5'h0, 2'h0, 3'h3));
    pulse(4'hb, 4'ha);
    sts(32'h2, RUN);
    pulse(4'hf, 4'ha);
    sts(32'h3, RUN);
    pulse(4'h8, 4'ha);
    sts(32'h2, RUN);
    done("pair");
    wreg(`DIMAC_A_CTRL, ctl(5'h0, 2'h0, 3'h4));
    for (int i = 0; i < 4; i++) begin
      term({1'b1, 2'(i), 1'b1});
      spd(pre[i]);
      sts(32'h3, RUN);
    end
    term(4'h8);
    term(4'h0);
    sts(32'h28, TRP);
    wreg(`DIMAC_A_KEY, 32'h4);
    done("preset");
    wreg(`DIMAC_A_CTRL, ctl(5'h3, 2'h1, 3'h0));
    term(4'h1);
    sts(32'h1, RUN);
    spd(pre[0]);
    pulse(4'h3, 4'h1);
    spd(pre[0] << 1);
    for (int k = 0; k < 3; k++) begin
      pulse(4'h5, 4'h1);
      spd((k == 0) ? pre[0] : 32'h0);
    end
    term(4'h0);
    wreg(`DIMAC_A_CTRL, ctl(5'h2, 2'h1, 3'h0));
    term(4'h1);
    sts(32'h0, RUN);
    wreg(`DIMAC_A_KEY, 32'h1);
    sts(32'h1, RUN);
    wreg(`DIMAC_A_KEY, 32'h2);
    sts(32'h0, RUN);
    term(4'h0);
    done("keypad");
    wreg(`DIMAC_A_CTRL, ctl(5'h0, 2'h2, 3'h0));
    fbp(1'b1);
    sts(32'h0, RUN);
    term(4'h1);
    fbp(1'b1);
    sts(32'h1, RUN);
    spd(fb);
    wreg(`DIMAC_A_CTRL, ctl(5'h0, 2'h3, 3'h0));
    spd(ml);
    fbp(1'b0);
    sts(32'h0, RUN);
    done("fieldbus");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sts(32'h10, LCK | RUN);
    term(4'h0);
    sts(32'h0, LCK);
    term(4'h1);
    sts(32'h1, RUN);
    done("power-up");
    repeat (4) @(posedge sys_clk);
    conclude();
  end
endmodule : testbench
`default_nettype wire
